//--- include/rpm_cfg.svh
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH
// register offsets on the control bus
`define RPM_REG_PWR 8'h09
`define RPM_REG_RATIO 8'h0A
`define RPM_REG_TERM 8'h0B
`define RPM_REG_SWING 8'h0C
// field positions
`define RPM_PD_BIT 3
`define RPM_RATIO_BIT 1
`define RPM_TERM_LSB 3
`define RPM_SLEW_LSB 6
`define RPM_EMPH_LSB 0
`define RPM_SWING_LSB 2
// reset values
`define RPM_SLEW_RST 2'h0
`define RPM_SWING_RST 6'h00
`define RPM_READ_NONE 8'h00
// three-level strap codes from the pad detector
`define RPM_STRAP_LOW 2'h0
`define RPM_STRAP_MID 2'h1
`define RPM_STRAP_HIGH 2'h2
// strap derived defaults
`define RPM_TERM_NONE 2'h0
`define RPM_TERM_HIGH_Z 2'h3
`define RPM_EMPH_0DB 2'h0
`define RPM_EMPH_LOW 2'h1
`define RPM_EMPH_HIGH 2'h2
// control bus slave address, value arbitrary
`define RPM_SLAVE_ADDR 7'h2C
`endif

//--- include/rpm_pkg.sv
package rpm_pkg;
  // power state of the retimer
  typedef enum logic [1:0] {
    RPM_PWR_OFF = 2'b00,
    RPM_PWR_DOWN = 2'b01,
    RPM_PWR_NORMAL = 2'b10
  } rpm_pwr_e;
  // control bus slave sequencer
  typedef enum logic [2:0] {
    RPM_BUS_IDLE = 3'b000,
    RPM_BUS_ADDR = 3'b001,
    RPM_BUS_ACK = 3'b010,
    RPM_BUS_WDATA = 3'b011,
    RPM_BUS_RDATA = 3'b100,
    RPM_BUS_RACK = 3'b101
  } rpm_bus_e;
  // register file state
  typedef struct packed {
    logic pd_force;
    logic ratio;
    logic [1:0] term;
    logic [1:0] slew;
    logic [1:0] emph;
    logic [5:0] swing;
    logic term_auto;
  } rpm_regs_s;
  // top-level state
  typedef struct packed {
    logic en_d;
    logic scl_d;
    logic sda_d;
    rpm_bus_e bus;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ptr_phase;
    logic rd;
    logic nack;
    logic drive;
    logic wr;
    logic [7:0] wdata;
    logic clr;
    rpm_pwr_e pwr;
    logic hpd;
    logic lanes_hiz;
    logic rx_en;
    logic tx_en;
    logic cdr_en;
    logic chan_en;
    logic ctl_en;
    logic retimer;
    logic sda_out;
  } rpm_top_s;
endpackage : rpm_pkg

//--- include/rpm_reg_if.sv
`timescale 1ns/1ps
interface rpm_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic clr;
  logic [1:0] strap_term;
  logic [1:0] strap_emph;
  logic ratio_clr;
  rpm_pkg::rpm_regs_s regs;
  // sequencer side
  modport ctl (output wr, waddr, wdata, raddr, clr, strap_term, strap_emph, ratio_clr,
    input rdata, regs);
  // register side
  modport regfile (input wr, waddr, wdata, raddr, clr, strap_term, strap_emph, ratio_clr,
    output rdata, regs);
endinterface : rpm_reg_if

//--- verilog/rpm_sync.sv
`timescale 1ns/1ps
module rpm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rpm_sync_s;
  rpm_sync_s st, next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;
endmodule : rpm_sync

//--- verilog/rpm_regfile.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module rpm_regfile (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register access
  rpm_reg_if.regfile rif
);
  import rpm_pkg::*;
  rpm_regs_s st, next_st;
  logic [1:0] def_term;
  logic [1:0] def_emph;

  // strap levels decide the defaults; a floating pin means auto term and 0 dB
  always_comb begin
    def_term = `RPM_TERM_NONE;
    def_emph = `RPM_EMPH_0DB;
    if (rif.strap_term == `RPM_STRAP_HIGH) begin
      def_term = `RPM_TERM_HIGH_Z;
    end
    if (rif.strap_emph == `RPM_STRAP_LOW) begin
      def_emph = `RPM_EMPH_LOW;
    end else if (rif.strap_emph == `RPM_STRAP_HIGH) begin
      def_emph = `RPM_EMPH_HIGH;
    end
  end

  // writes, clear on enable rise, ratio flag dropped in power-down
  always_comb begin
    next_st = st;
    if (rif.clr) begin
      next_st = '0;
      next_st.term = def_term;
      next_st.slew = `RPM_SLEW_RST;
      next_st.emph = def_emph;
      next_st.swing = `RPM_SWING_RST;
      next_st.term_auto = (rif.strap_term == `RPM_STRAP_MID);
    end else if (rif.wr) begin
      unique case (rif.waddr)
        `RPM_REG_PWR: next_st.pd_force = rif.wdata[`RPM_PD_BIT];
        `RPM_REG_RATIO: next_st.ratio = rif.wdata[`RPM_RATIO_BIT];
        `RPM_REG_TERM: begin
          next_st.term = rif.wdata[`RPM_TERM_LSB +: 2];
          next_st.slew = rif.wdata[`RPM_SLEW_LSB +: 2];
          next_st.term_auto = 1'b0; // host choice overrides auto select
        end
        `RPM_REG_SWING: begin
          next_st.emph = rif.wdata[`RPM_EMPH_LSB +: 2];
          next_st.swing = rif.wdata[`RPM_SWING_LSB +: 6];
        end
        default: next_st = st;
      endcase
    end
    // clearing wins here: the pll must not keep a stale ratio across power-down
    if (rif.ratio_clr) begin
      next_st.ratio = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rif.rdata = `RPM_READ_NONE;
    unique case (rif.raddr)
      `RPM_REG_PWR: rif.rdata[`RPM_PD_BIT] = st.pd_force;
      `RPM_REG_RATIO: rif.rdata[`RPM_RATIO_BIT] = st.ratio;
      `RPM_REG_TERM: rif.rdata = {st.slew, 1'b0, st.term, 3'h0};
      `RPM_REG_SWING: rif.rdata = {st.swing, st.emph};
      default: rif.rdata = `RPM_READ_NONE;
    endcase
  end

  assign rif.regs = st;
endmodule : rpm_regfile

//--- verilog/rpm_top.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
// Overview of operation
// - enable low shuts all blocks but the hot-plug mirror: lanes high-z, control bus and channels off
// - enable rising edge resets every configuration field to its default
// - enable high, hot-plug low: power-down, control bus slave still active
// - power-down bit in register 09h forces power-down, bus stays responsive
// - source hot-plug output always follows sink hot-plug input
// - after hot-plug, recovery and drivers enable only with signal detected
// - enable, hot-plug high, no power-down: full redriver or retimer operation
// - clock-ratio flag is cleared in every power-down state
// - termination field at 0Bh bits 4:3 selects none, 150-300 or 75-150 ohm
// - edge-rate field at 0Bh bits 7:6, value 10 suggested
// - pre-emphasis field at 0Ch bits 1:0, 00 and 01 selectable
// - lane swing adjust at 0Ch bits 7:2, all ones lowers swing
// - floating straps give automatic termination and 0 dB emphasis
module rpm_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // power and hot-plug pins
  input wire logic enable_i,
  input wire logic sink_hotplug_in_i,
  output logic source_hotplug_out_o,
  // analog status inputs
  input wire logic sig_detect_i,
  input wire logic rate_above_1g_i,
  // three-level strap pads
  input wire logic [1:0] term_strap_i,
  input wire logic [1:0] emph_strap_i,
  // control bus pins, open drain
  input wire logic control_bus_clock_line_i,
  input wire logic control_bus_data_line_i,
  output logic control_bus_data_line_o,
  output logic control_bus_data_line_oe_n_o,
  // lane and channel controls
  output logic lanes_hiz_o,
  output logic rx_enable_o,
  output logic tx_enable_o,
  output logic cdr_enable_o,
  output logic channel_enable_o,
  output logic control_bus_active_o,
  output logic retimer_mode_o,
  output rpm_pkg::rpm_pwr_e power_state_o,
  // output driver configuration
  output logic [1:0] output_termination_select_o,
  output logic output_termination_auto_o,
  output logic [1:0] edge_rate_select_o,
  output logic [1:0] emphasis_select_o,
  output logic [5:0] lane_swing_adjust_o,
  output logic clock_ratio_flag_o
);
  import rpm_pkg::*;

  localparam int SYNC_W = 10;

  rpm_top_s st, next_st;
  rpm_reg_if rif ();
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_q;
  logic en_s;
  logic hpd_s;
  logic sigdet_s;
  logic rate_s;
  logic scl_s;
  logic sda_s;
  logic [1:0] term_strap_s;
  logic [1:0] emph_strap_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] byte_in;

  // every pin from outside the clock domain passes two flops
  assign sync_raw = {enable_i, sink_hotplug_in_i, sig_detect_i, rate_above_1g_i,
    control_bus_clock_line_i, control_bus_data_line_i, term_strap_i, emph_strap_i};

  rpm_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sync_raw),
    .sync_o(sync_q)
  );

  // split the synchronised word into named levels; nothing reads a raw pin, so a
  // change that lands near a clock edge cannot steer two decisions apart
  assign {en_s, hpd_s, sigdet_s, rate_s, scl_s, sda_s, term_strap_s, emph_strap_s} = sync_q;

  rpm_regfile u_regfile (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .rif(rif.regfile)
  );

  // edges seen on the synchronised bus lines only; both lines share the same
  // two-flop delay, so their order on the wire is kept
  assign scl_rise = scl_s & ~st.scl_d;
  assign scl_fall = ~scl_s & st.scl_d;
  assign bus_start = scl_s & st.scl_d & st.sda_d & ~sda_s;
  assign bus_stop = scl_s & st.scl_d & ~st.sda_d & sda_s;
  assign byte_in = {st.sh[6:0], sda_s};

  // register side of the sequencer
  // the ratio flag is held clear while any power-down state is registered
  assign rif.wr = st.wr;
  assign rif.waddr = st.ptr;
  assign rif.wdata = st.wdata;
  assign rif.raddr = st.ptr;
  assign rif.clr = st.clr;
  assign rif.strap_term = term_strap_s;
  assign rif.strap_emph = emph_strap_s;
  assign rif.ratio_clr = (st.pwr != RPM_PWR_NORMAL);

  // next state: control bus slave and power sequencing
  always_comb begin
    next_st = st;
    next_st.en_d = en_s;
    next_st.scl_d = scl_s;
    next_st.sda_d = sda_s;
    next_st.wr = 1'b0;
    next_st.sda_out = 1'b0;
    // a rising enable is a full configuration reset
    // held through the whole low phase too, so the straps are taken at the rise
    next_st.clr = (en_s & ~st.en_d) | ~en_s;

    // control bus slave
    if (!en_s) begin
      next_st.bus = RPM_BUS_IDLE;
      next_st.drive = 1'b0;
      next_st.ptr = 8'h00;
    end else if (bus_start) begin
      next_st.bus = RPM_BUS_ADDR;
      next_st.bits = 4'h0;
      next_st.drive = 1'b0;
    end else if (bus_stop) begin
      next_st.bus = RPM_BUS_IDLE;
      next_st.drive = 1'b0;
    end else begin
      unique case (st.bus)
        RPM_BUS_IDLE: begin
          next_st.drive = 1'b0;
        end
        // address byte: shift on scl rise, decide after the eighth bit
        RPM_BUS_ADDR: begin
          if (scl_rise) begin
            next_st.sh = byte_in;
            next_st.bits = st.bits + 4'h1;
          end else if (scl_fall && st.bits == 4'h8) begin
            if (st.sh[7:1] == `RPM_SLAVE_ADDR) begin
              next_st.drive = 1'b1; // acknowledge the address
              next_st.rd = st.sh[0];
              next_st.ptr_phase = ~st.sh[0];
              next_st.bus = RPM_BUS_ACK;
            end else begin
              next_st.bus = RPM_BUS_IDLE; // not ours, stay off the bus
            end
          end
        end
        // ack slot: the level set after one scl fall holds until the next fall;
        // a read loads its byte here so bit 7 stands before scl rises again
        RPM_BUS_ACK: begin
          if (scl_fall) begin
            next_st.bits = 4'h0;
            if (st.rd) begin
              next_st.sh = rif.rdata;
              next_st.drive = ~rif.rdata[7];
              next_st.bus = RPM_BUS_RDATA;
            end else begin
              next_st.drive = 1'b0;
              next_st.bus = RPM_BUS_WDATA;
            end
          end
        end
        RPM_BUS_WDATA: begin
          if (scl_rise) begin
            next_st.sh = byte_in;
            next_st.bits = st.bits + 4'h1;
          end else if (scl_fall && st.bits == 4'h8) begin
            // first byte sets the pointer, later bytes write and advance it
            if (st.ptr_phase) begin
              next_st.ptr = st.sh;
              next_st.ptr_phase = 1'b0;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = st.sh;
            end
            next_st.drive = 1'b1;
            next_st.bus = RPM_BUS_ACK;
          end
        end
        // read data: next bit set after each fall; a master that gives up mid-byte
        // cannot hang us, since a start or stop from any state resynchronises
        RPM_BUS_RDATA: begin
          if (scl_rise) begin
            next_st.bits = st.bits + 4'h1;
          end else if (scl_fall) begin
            if (st.bits == 4'h8) begin
              next_st.drive = 1'b0; // release for the master's ack
              next_st.ptr = st.ptr + 8'h01;
              next_st.bus = RPM_BUS_RACK;
            end else begin
              next_st.sh = {st.sh[6:0], 1'b0};
              next_st.drive = ~st.sh[6];
            end
          end
        end
        // master ack slot: low asks for the next byte at the advanced pointer
        RPM_BUS_RACK: begin
          if (scl_rise) begin
            next_st.nack = sda_s;
          end else if (scl_fall) begin
            next_st.bits = 4'h0;
            if (st.nack) begin
              next_st.bus = RPM_BUS_IDLE;
            end else begin
              next_st.sh = rif.rdata;
              next_st.drive = ~rif.rdata[7];
              next_st.bus = RPM_BUS_RDATA;
            end
          end
        end
        default: begin
          next_st.bus = RPM_BUS_IDLE;
          next_st.drive = 1'b0;
        end
      endcase
    end

    // a write issued in data phase last cycle advances the pointer here
    if (st.wr) begin
      next_st.ptr = st.ptr + 8'h01;
    end

    // power state from synchronised levels and the forced power-down bit;
    // enable outranks hot-plug, which outranks the bit, so a forced power-down
    // never hides the off state from the lanes
    if (!en_s) begin
      next_st.pwr = RPM_PWR_OFF;
    end else if (!hpd_s) begin
      next_st.pwr = RPM_PWR_DOWN;
    end else if (rif.regs.pd_force) begin
      next_st.pwr = RPM_PWR_DOWN;
    end else begin
      next_st.pwr = RPM_PWR_NORMAL;
    end

    // hot-plug is mirrored regardless of power state
    next_st.hpd = hpd_s;

    // lane and channel enables follow the power state
    next_st.ctl_en = (next_st.pwr != RPM_PWR_OFF);
    next_st.lanes_hiz = (next_st.pwr != RPM_PWR_NORMAL);
    next_st.rx_en = (next_st.pwr == RPM_PWR_NORMAL);
    next_st.chan_en = (next_st.pwr == RPM_PWR_NORMAL);
    // recovery and drivers wait for the signal detector
    next_st.cdr_en = (next_st.pwr == RPM_PWR_NORMAL) & sigdet_s;
    next_st.tx_en = (next_st.pwr == RPM_PWR_NORMAL) & sigdet_s;
    next_st.retimer = (next_st.pwr == RPM_PWR_NORMAL) & rate_s;
  end

  // single state register
  // reset leaves the lanes high-z and the delayed bus lines high; the synchroniser starts low, so scl shows a false fall and rise
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.en_d <= 1'b0;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
      st.bus <= RPM_BUS_IDLE;
      st.pwr <= RPM_PWR_OFF;
      st.lanes_hiz <= 1'b1;
      st.clr <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  // the data line value is fixed low; only its enable moves, as open drain needs
  assign source_hotplug_out_o = st.hpd;
  assign control_bus_data_line_o = st.sda_out;
  assign control_bus_data_line_oe_n_o = ~st.drive;
  assign lanes_hiz_o = st.lanes_hiz;
  assign rx_enable_o = st.rx_en;
  assign tx_enable_o = st.tx_en;
  assign cdr_enable_o = st.cdr_en;
  assign channel_enable_o = st.chan_en;
  assign control_bus_active_o = st.ctl_en;
  assign retimer_mode_o = st.retimer;
  assign power_state_o = st.pwr;
  // configuration fields come from the register file flops
  assign output_termination_select_o = rif.regs.term;
  assign output_termination_auto_o = rif.regs.term_auto;
  assign edge_rate_select_o = rif.regs.slew;
  assign emphasis_select_o = rif.regs.emph;
  assign lane_swing_adjust_o = rif.regs.swing;
  assign clock_ratio_flag_o = rif.regs.ratio;
endmodule : rpm_top

//--- verification/rpm_top_props.sv
`timescale 1ns/1ps
module rpm_top_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pins watched
  input wire logic enable_i,
  input wire logic sink_hotplug_in_i,
  input wire logic source_hotplug_out_o,
  input wire logic sig_detect_i,
  input wire logic rate_above_1g_i,
  input wire logic control_bus_data_line_o,
  input wire logic control_bus_data_line_oe_n_o,
  // lane and channel controls
  input wire logic lanes_hiz_o,
  input wire logic rx_enable_o,
  input wire logic tx_enable_o,
  input wire logic cdr_enable_o,
  input wire logic channel_enable_o,
  input wire logic control_bus_active_o,
  input wire logic retimer_mode_o,
  input wire rpm_pkg::rpm_pwr_e power_state_o,
  // configuration fields
  input wire logic [1:0] edge_rate_select_o,
  input wire logic [5:0] lane_swing_adjust_o,
  input wire logic clock_ratio_flag_o
);
  import rpm_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // pin windows of five cycles cover two sync flops plus the state flop
  a_off_shuts_all: assert property (!enable_i [*5] |-> power_state_o == RPM_PWR_OFF
    && lanes_hiz_o && !control_bus_active_o && !channel_enable_o && control_bus_data_line_oe_n_o)
    else $error("enable low did not shut the blocks");
  a_sda_pull_low: assert property (!control_bus_data_line_oe_n_o |->
    !control_bus_data_line_o && control_bus_active_o)
    else $error("data line driven while bus off");
  a_hpd_down: assert property (enable_i && !sink_hotplug_in_i [*5] |->
    power_state_o == RPM_PWR_DOWN && control_bus_active_o)
    else $error("hot-plug low did not power down");
  a_ctl_active: assert property (control_bus_active_o == (power_state_o != RPM_PWR_OFF))
    else $error("control bus activity wrong for state");
  a_down_lanes_hiz: assert property (power_state_o != RPM_PWR_NORMAL |-> lanes_hiz_o
    && !rx_enable_o && !tx_enable_o && !cdr_enable_o && !channel_enable_o && !retimer_mode_o)
    else $error("lanes active outside normal");
  a_norm_lanes_on: assert property (power_state_o == RPM_PWR_NORMAL |->
    !lanes_hiz_o && rx_enable_o && channel_enable_o)
    else $error("normal state without receivers");
  a_mirror_hpd: assert property ($stable(sink_hotplug_in_i) [*5] |->
    source_hotplug_out_o == sink_hotplug_in_i)
    else $error("source hot-plug does not follow sink");
  // the drivers show the detector level of three clocks before, so it must hold still
  a_tx_by_detect: assert property ($stable(sig_detect_i) [*5] ##0
    ($stable(sig_detect_i) && power_state_o == RPM_PWR_NORMAL) [*3] |->
    tx_enable_o == sig_detect_i && cdr_enable_o == sig_detect_i)
    else $error("drivers not gated by signal detect");
  a_retimer_rate: assert property ($stable(rate_above_1g_i) [*5] ##0
    ($stable(rate_above_1g_i) && power_state_o == RPM_PWR_NORMAL) [*3] |->
    retimer_mode_o == rate_above_1g_i)
    else $error("retimer mode not set by rate");
  a_ratio_cleared: assert property ((power_state_o != RPM_PWR_NORMAL) [*2] |->
    !clock_ratio_flag_o)
    else $error("ratio flag kept in power-down");
  a_rise_defaults: assert property ($rose(enable_i) |-> ##[1:6]
    edge_rate_select_o == 2'h0 && lane_swing_adjust_o == 6'h00)
    else $error("enable rise kept old settings");
endmodule : rpm_top_props

//--- verification/rpm_host_model.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module rpm_host_model (
  // clock
  input wire logic clk_i,
  // wire level and open-drain drives
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // idle bus is released high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // eight clocks keep each scl phase above the slave minimum
  task hp;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : hp
  // data moves only mid low phase, so start and stop are never mimicked
  task bit_io(input logic v, output logic s);
    sda_o = v;
    hp();
    scl_o = 1'b1;
    hp();
    s = sda_i;
    scl_o = 1'b0;
    hp();
  endtask : bit_io
  task start;
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
    hp();
  endtask : start
  task stop;
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask : stop
  task tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : tx
  // master nack after one byte ends the read
  task rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
  endtask : rx
  task wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx({dev, 1'b0}, a0);
    tx(ptr, a1);
    tx(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  task rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start();
    tx({`RPM_SLAVE_ADDR, 1'b0}, a);
    tx(ptr, a);
    start();
    tx({`RPM_SLAVE_ADDR, 1'b1}, a);
    rx(d);
    stop();
  endtask : rd
endmodule : rpm_host_model

//--- verification/tb.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
`define CHK(n, e, a) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("BAD %s exp %0h got %0h", n, (e), (a)); \
  end \
end
module tb;
  import rpm_pkg::*;
  logic clk_i, reset_i, enable_i, sink_hotplug_in_i, sig_detect_i, rate_above_1g_i;
  logic [1:0] term_strap_i, emph_strap_i, output_termination_select_o;
  logic [1:0] edge_rate_select_o, emphasis_select_o;
  logic control_bus_clock_line_i, control_bus_data_line_i, control_bus_data_line_o;
  logic control_bus_data_line_oe_n_o, source_hotplug_out_o, lanes_hiz_o, rx_enable_o;
  logic tx_enable_o, cdr_enable_o, channel_enable_o, control_bus_active_o, retimer_mode_o;
  logic output_termination_auto_o, clock_ratio_flag_o, host_sda, ok;
  logic [5:0] lane_swing_adjust_o;
  logic [7:0] d;
  rpm_pwr_e power_state_o;
  int failures = 0;
  int tests_run = 0;
  // rows: enable, hot-plug, detect, rate | state, high-z, tx, retimer
  logic [8:0] rows [6] = '{9'b0111_00_100, 9'b1011_01_100, 9'b1101_10_001,
    9'b1110_10_010, 9'b1111_10_011, 9'b0000_00_100};
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
  // strap rows: term pad, emphasis pad | term, emphasis expected
  logic [7:0] straps [2] = '{8'h8D, 8'h22};
  // open drain: a released line rises through the pull-up
  assign control_bus_data_line_i = host_sda &
    (control_bus_data_line_oe_n_o | control_bus_data_line_o);
  rpm_top i_dut (.clk_i, .reset_i, .enable_i, .sink_hotplug_in_i, .source_hotplug_out_o,
    .sig_detect_i, .rate_above_1g_i, .term_strap_i, .emph_strap_i, .control_bus_clock_line_i,
    .control_bus_data_line_i, .control_bus_data_line_o, .control_bus_data_line_oe_n_o,
    .lanes_hiz_o, .rx_enable_o, .tx_enable_o, .cdr_enable_o, .channel_enable_o,
    .control_bus_active_o, .retimer_mode_o, .power_state_o, .output_termination_select_o,
    .output_termination_auto_o, .edge_rate_select_o, .emphasis_select_o,
    .lane_swing_adjust_o, .clock_ratio_flag_o);
  rpm_host_model i_host (.clk_i(clk_i), .sda_i(control_bus_data_line_i),
    .scl_o(control_bus_clock_line_i), .sda_o(host_sda));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task stop_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // whole sequence needs about 14k cycles; this cuts a hang well past that
  initial begin
    #300000;
    failures++;
    stop_test();
  end
  initial begin
    reset_i = 1'b1;
    {enable_i, sink_hotplug_in_i, sig_detect_i, rate_above_1g_i} = 4'h0;
    term_strap_i = `RPM_STRAP_MID;
    emph_strap_i = `RPM_STRAP_MID;
    repeat (16) @(posedge clk_i);
    #1 reset_i = 1'b0;
    cyc(2);
    `CHK("rst state", RPM_PWR_OFF, power_state_o)
    `CHK("rst oe_n", 1'b1, control_bus_data_line_oe_n_o)
    foreach (rows[k]) begin
      {enable_i, sink_hotplug_in_i, sig_detect_i, rate_above_1g_i} = rows[k][8:5];
      cyc(8);
      `CHK("state", rows[k][4:3], power_state_o)
      `CHK("hiz", rows[k][2], lanes_hiz_o)
      `CHK("tx", rows[k][1], tx_enable_o)
      `CHK("retimer", rows[k][0], retimer_mode_o)
      `CHK("mirror", sink_hotplug_in_i, source_hotplug_out_o)
    end
    // enable rise with floating straps picks the automatic defaults
    {enable_i, sink_hotplug_in_i, sig_detect_i, rate_above_1g_i} = 4'hF;
    cyc(8);
    `CHK("term auto", 1'b1, output_termination_auto_o)
    `CHK("emph 0db", 2'h0, emphasis_select_o)
    `CHK("edge rst", 2'h0, edge_rate_select_o)
    foreach (codes[k]) begin
      i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_TERM, {2'h2, 1'b1, codes[k], 3'h7}, ok);
      i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_SWING, {6'h3F, 1'b0, codes[k][0]}, ok);
      cyc(4);
      `CHK("term", codes[k], output_termination_select_o)
      `CHK("term man", 1'b0, output_termination_auto_o)
      `CHK("edge", 2'h2, edge_rate_select_o)
      `CHK("emph", {1'b0, codes[k][0]}, emphasis_select_o)
      `CHK("swing", 6'h3F, lane_swing_adjust_o)
      i_host.rd(`RPM_REG_TERM, d);
      `CHK("term rd", {2'h2, 1'b0, codes[k], 3'h0}, d)
    end
    // host sets the ratio flag, then forces power-down over the bus
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_RATIO, 8'h02, ok);
    cyc(4);
    `CHK("ratio set", 1'b1, clock_ratio_flag_o)
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_PWR, 8'h08, ok);
    cyc(4);
    `CHK("forced down", RPM_PWR_DOWN, power_state_o)
    `CHK("ratio clr", 1'b0, clock_ratio_flag_o)
    i_host.rd(`RPM_REG_PWR, d);
    `CHK("pd rd", 8'h08, d)
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_PWR, 8'h00, ok);
    cyc(4);
    `CHK("back normal", RPM_PWR_NORMAL, power_state_o)
    // hot-plug low: bus still answers, but the clear beats the write
    sink_hotplug_in_i = 1'b0;
    cyc(8);
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_RATIO, 8'h02, ok);
    cyc(4);
    `CHK("down ack", 1'b1, ok)
    `CHK("ratio down", 1'b0, clock_ratio_flag_o)
    sink_hotplug_in_i = 1'b1;
    i_host.wr(`RPM_SLAVE_ADDR, 8'h20, 8'hFF, ok);
    i_host.rd(8'h20, d);
    `CHK("unmapped", 8'h00, d)
    // enable low ignores the bus; the rise wipes the programming
    enable_i = 1'b0;
    cyc(8);
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_SWING, 8'h00, ok);
    `CHK("off ack", 1'b0, ok)
    enable_i = 1'b1;
    cyc(8);
    `CHK("swing rst", 6'h00, lane_swing_adjust_o)
    `CHK("edge rst2", 2'h0, edge_rate_select_o)
    i_host.wr(`RPM_SLAVE_ADDR, `RPM_REG_SWING, 8'hFC, ok);
    cyc(4);
    `CHK("reprog", 6'h3F, lane_swing_adjust_o)
    // strapped pads pick fixed defaults at the next enable rise
    foreach (straps[k]) begin
      {term_strap_i, emph_strap_i} = straps[k][7:4];
      enable_i = 1'b0;
      cyc(8);
      enable_i = 1'b1;
      cyc(8);
      `CHK("strap term", straps[k][3:2], output_termination_select_o)
      `CHK("strap emph", straps[k][1:0], emphasis_select_o)
      `CHK("strap auto", 1'b0, output_termination_auto_o)
    end
    stop_test();
  end
endmodule : tb
bind rpm_top rpm_top_props i_props (.clk_i, .reset_i, .enable_i, .sink_hotplug_in_i,
  .source_hotplug_out_o, .sig_detect_i, .rate_above_1g_i, .control_bus_data_line_o,
  .control_bus_data_line_oe_n_o, .lanes_hiz_o, .rx_enable_o, .tx_enable_o, .cdr_enable_o,
  .channel_enable_o, .control_bus_active_o, .retimer_mode_o, .power_state_o,
  .edge_rate_select_o, .lane_swing_adjust_o, .clock_ratio_flag_o);
